// ===== core/fpm_regs.svh
`ifndef FPM_REGS_SVH
`define FPM_REGS_SVH

// ----------------------------------------------------------------
// Defaults and limits
// ----------------------------------------------------------------
`define FPM_FORMAT_WIDTH_DEF 16
`define FPM_EXP_WIDTH_DEF    5
`define FPM_PIPE_REGS_MAX    4
`define FPM_TIED_HIGH        1'b1
`define FPM_DATA_RST         '0

`endif

// ===== core/fpm_pkg.sv
package fpm_pkg;
    // Declaration order gives 00 normal, 01 zero, 10 infinity, 11 underflow
    typedef enum logic [1:0] {
        FPM_ST_NORMAL,
        FPM_ST_ZERO,
        FPM_ST_INF,
        FPM_ST_UFLOW
    } fpm_status_e;
endpackage : fpm_pkg

// ===== core/fpm_fmul.sv
`timescale 1ns/1ps
module fpm_fmul
    import fpm_pkg::*;
#(
    parameter int FORMAT_WIDTH = 16,
    parameter int EXP_WIDTH    = 5
) (
    // Operands
    input  wire logic [FORMAT_WIDTH-1:0] op_a,
    input  wire logic [FORMAT_WIDTH-1:0] op_b,
    // Result
    output logic      [FORMAT_WIDTH-1:0] prod,
    output fpm_status_e                  status
);
    localparam int W = FORMAT_WIDTH;
    localparam int E = EXP_WIDTH;
    localparam int M = W - 1 - E;
    localparam logic signed [E+1:0] BIAS_S = (E+2)'((1 << (E - 1)) - 1);
    localparam logic signed [E+1:0] EMAX_S = (E+2)'((1 << E) - 1);

    logic              sgn;
    logic [2*M+1:0]    mp;
    logic              nrm;
    logic [M-1:0]      mres;
    logic signed [E+1:0] es;

    // Subnormals flush to zero; any infinity or NaN operand gives infinity
    always_comb begin
        sgn  = op_a[W-1] ^ op_b[W-1];
        mp   = {1'b1, op_a[M-1:0]} * {1'b1, op_b[M-1:0]};
        nrm  = mp[2*M+1];
        mres = nrm ? mp[2*M:M+1] : mp[2*M-1:M];
        es   = $signed({2'b00, op_a[W-2:M]}) + $signed({2'b00, op_b[W-2:M]})
             - BIAS_S + $signed({{(E+1){1'b0}}, nrm});
        if ((&op_a[W-2:M]) || (&op_b[W-2:M])) begin
            prod   = {sgn, {E{1'b1}}, {M{1'b0}}};
            status = FPM_ST_INF;
        end else if (op_a[W-2:M] == '0 || op_b[W-2:M] == '0) begin
            prod   = {sgn, {(W-1){1'b0}}};
            status = FPM_ST_ZERO;
        end else if (es >= EMAX_S) begin
            prod   = {sgn, {E{1'b1}}, {M{1'b0}}};
            status = FPM_ST_INF;
        end else if (es <= 0) begin
            prod   = {sgn, {(W-1){1'b0}}};
            status = FPM_ST_UFLOW;
        end else begin
            prod   = {sgn, es[E-1:0], mres};
            status = FPM_ST_NORMAL;
        end
    end
endmodule : fpm_fmul

// ===== core/fpm_fadd.sv
`timescale 1ns/1ps
module fpm_fadd
    import fpm_pkg::*;
#(
    parameter int FORMAT_WIDTH = 16,
    parameter int EXP_WIDTH    = 5
) (
    // Operands
    input  wire logic [FORMAT_WIDTH-1:0] op_a,
    input  wire logic [FORMAT_WIDTH-1:0] op_b,
    // Result
    output logic      [FORMAT_WIDTH-1:0] sum,
    output fpm_status_e                  status
);
    localparam int W = FORMAT_WIDTH;
    localparam int E = EXP_WIDTH;
    localparam int M = W - 1 - E;
    localparam logic signed [E+1:0] EMAX_S = (E+2)'((1 << E) - 1);

    logic [W-1:0]        big;
    logic [W-1:0]        sml;
    logic [E-1:0]        diff;
    logic [M+1:0]        mbig;
    logic [M+1:0]        msml;
    logic [M+1:0]        msum;
    logic [M+1:0]        mshf;
    logic [E+1:0]        lz;
    logic                found;
    logic signed [E+1:0] ex;

    // Truncating adder; cancellation to zero gives plus zero
    always_comb begin
        big   = op_a;
        sml   = op_b;
        if (op_b[W-2:0] > op_a[W-2:0]) begin
            big = op_b;
            sml = op_a;
        end
        diff  = big[W-2:M] - sml[W-2:M];
        mbig  = {2'b01, big[M-1:0]};
        msml  = {2'b01, sml[M-1:0]} >> diff;
        msum  = (big[W-1] ^ sml[W-1]) ? mbig - msml : mbig + msml;
        ex    = $signed({2'b00, big[W-2:M]});
        lz    = '0;
        found = 1'b0;
        for (int i = M; i >= 0; i--) begin
            if (!found && !msum[i]) lz = lz + 1'b1;
            else found = 1'b1;
        end
        mshf  = msum << lz;
        sum    = {big[W-1], {(W-1){1'b0}}};
        status = FPM_ST_ZERO;
        if (&big[W-2:M]) begin
            sum    = {big[W-1], {E{1'b1}}, {M{1'b0}}};
            status = FPM_ST_INF;
        end else if (big[W-2:M] == '0) begin
            sum    = {big[W-1] & sml[W-1], {(W-1){1'b0}}};
        end else if (sml[W-2:M] == '0) begin
            sum    = {big[W-1], big[W-2:0]};
            status = FPM_ST_NORMAL;
        end else if (msum == '0) begin
            sum    = '0;
        end else begin
            if (msum[M+1]) begin
                mshf = msum >> 1;
                ex   = ex + (E+2)'(1);
            end else begin
                ex   = ex - $signed(lz);
            end
            if (ex >= EMAX_S) begin
                sum    = {big[W-1], {E{1'b1}}, {M{1'b0}}};
                status = FPM_ST_INF;
            end else if (ex <= 0) begin
                status = FPM_ST_UFLOW;
            end else begin
                sum    = {big[W-1], ex[E-1:0], mshf[M-1:0]};
                status = FPM_ST_NORMAL;
            end
        end
    end
endmodule : fpm_fadd

// ===== core/fpm_mac.sv
`timescale 1ns/1ps
`include "fpm_regs.svh"
module fpm_mac
    import fpm_pkg::*;
#(
    parameter int FORMAT_WIDTH   = `FPM_FORMAT_WIDTH_DEF,
    parameter int EXP_WIDTH      = `FPM_EXP_WIDTH_DEF,
    parameter bit ACCUM_EN       = 1'b0,
    parameter bit IN_REG_EN      = 1'b0,
    parameter int PIPE_REGS      = 0,
    parameter bit HIDE_IN_CTRL   = 1'b0,
    parameter bit HIDE_PIPE_CTRL = 1'b0
) (
    // Clock and global reset
    input  wire logic                    mclk,
    input  wire logic                    reset,
    // Operands and load
    input  wire logic [FORMAT_WIDTH-1:0] din_a,
    input  wire logic [FORMAT_WIDTH-1:0] din_b,
    input  wire logic                    load,
    // Input register control
    input  wire logic                    in_reg_a_ce,
    input  wire logic                    in_reg_b_ce,
    input  wire logic                    in_reg_rst_n,
    // Pipeline and accumulator control
    input  wire logic                    pipeline_ce,
    input  wire logic                    pipeline_rst_n,
    // Result
    output logic      [FORMAT_WIDTH-1:0] dout,
    output fpm_status_e                  status
);
    localparam int W  = FORMAT_WIDTH;
    localparam int DL = (PIPE_REGS > 1) ? PIPE_REGS - 1 : 1;

    // ----------------------------------------------------------------
    // Configuration checks
    // ----------------------------------------------------------------
    // Only fp16, fp16 with 8-bit exponent and fp24 are legal
    if (!((W == 16 && (EXP_WIDTH == 5 || EXP_WIDTH == 8)) ||
          (W == 24 && EXP_WIDTH == 8)))
        $error("format width and exponent width do not match");
    if (PIPE_REGS < 0 || PIPE_REGS > `FPM_PIPE_REGS_MAX)
        $error("pipeline register count out of range");

    // ----------------------------------------------------------------
    // Control tie-offs
    // ----------------------------------------------------------------
    logic ce_a;
    logic ce_b;
    logic in_rstn;
    logic pipe_ce;
    logic pipe_rstn;

    // Hidden controls read as logic one; absent ones are never used
    assign ce_a      = HIDE_IN_CTRL   ? `FPM_TIED_HIGH : in_reg_a_ce;
    assign ce_b      = HIDE_IN_CTRL   ? `FPM_TIED_HIGH : in_reg_b_ce;
    assign in_rstn   = HIDE_IN_CTRL   ? `FPM_TIED_HIGH : in_reg_rst_n;
    assign pipe_ce   = HIDE_PIPE_CTRL ? `FPM_TIED_HIGH : pipeline_ce;
    assign pipe_rstn = HIDE_PIPE_CTRL ? `FPM_TIED_HIGH : pipeline_rst_n;

    // ----------------------------------------------------------------
    // Input registers
    // ----------------------------------------------------------------
    logic [W-1:0] a_reg;
    logic [W-1:0] b_reg;
    logic         ld_reg;
    logic [W-1:0] a_op;
    logic [W-1:0] b_op;
    logic         ld_op;

    always_ff @(posedge mclk) begin
        if (reset || !in_rstn) begin
            a_reg <= `FPM_DATA_RST;
        end else if (ce_a) begin
            a_reg <= din_a;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || !in_rstn) begin
            b_reg <= `FPM_DATA_RST;
        end else if (ce_b) begin
            b_reg <= din_b;
        end
    end

    // Load follows the A enable so it stays paired with A's operand
    always_ff @(posedge mclk) begin
        if (reset || !in_rstn) begin
            ld_reg <= 1'b0;
        end else if (ce_a) begin
            ld_reg <= load;
        end
    end

    assign a_op  = IN_REG_EN ? a_reg : din_a;
    assign b_op  = IN_REG_EN ? b_reg : din_b;
    assign ld_op = ACCUM_EN & (IN_REG_EN ? ld_reg : load);

    // ----------------------------------------------------------------
    // Multiplier
    // ----------------------------------------------------------------
    logic [W-1:0] prod;
    fpm_status_e  prod_st;

    fpm_fmul #(
        .FORMAT_WIDTH (W),
        .EXP_WIDTH    (EXP_WIDTH)
    ) u_fmul (
        .op_a   (a_op),
        .op_b   (b_op),
        .prod   (prod),
        .status (prod_st)
    );

    // ----------------------------------------------------------------
    // Delay line ahead of the last stage
    // ----------------------------------------------------------------
    logic [W-1:0] dl_data [DL];
    fpm_status_e  dl_st   [DL];
    logic         dl_ld   [DL];
    logic [W-1:0] pd_data;
    fpm_status_e  pd_st;
    logic         pd_ld;

    // Stages clear together with the accumulator; a held enable freezes all
    always_ff @(posedge mclk) begin
        if (reset || !pipe_rstn) begin
            for (int i = 0; i < DL; i++) begin
                dl_data[i] <= `FPM_DATA_RST;
                dl_st[i]   <= FPM_ST_NORMAL;
                dl_ld[i]   <= 1'b0;
            end
        end else if (pipe_ce) begin
            dl_data[0] <= prod;
            dl_st[0]   <= prod_st;
            dl_ld[0]   <= ld_op;
            for (int i = 1; i < DL; i++) begin
                dl_data[i] <= dl_data[i-1];
                dl_st[i]   <= dl_st[i-1];
                dl_ld[i]   <= dl_ld[i-1];
            end
        end
    end

    assign pd_data = (PIPE_REGS > 1) ? dl_data[DL-1] : prod;
    assign pd_st   = (PIPE_REGS > 1) ? dl_st[DL-1]   : prod_st;
    assign pd_ld   = (PIPE_REGS > 1) ? dl_ld[DL-1]   : ld_op;

    // ----------------------------------------------------------------
    // Accumulator and last stage
    // ----------------------------------------------------------------
    logic [W-1:0] acc_reg;
    fpm_status_e  acc_st_reg;
    logic [W-1:0] sum_w;
    fpm_status_e  sum_st;
    logic [W-1:0] nxt_data;
    fpm_status_e  nxt_st;
    logic         last_ce;
    logic         last_rstn;

    fpm_fadd #(
        .FORMAT_WIDTH (W),
        .EXP_WIDTH    (EXP_WIDTH)
    ) u_fadd (
        .op_a   (acc_reg),
        .op_b   (pd_data),
        .sum    (sum_w),
        .status (sum_st)
    );

    always_comb begin
        nxt_data = pd_data;
        nxt_st   = pd_st;
        if (ACCUM_EN && !pd_ld) begin
            nxt_data = sum_w;
            nxt_st   = sum_st;
        end
    end

    // With no pipeline stages the enable and reset do not exist
    assign last_ce   = (PIPE_REGS > 0) ? pipe_ce   : 1'b1;
    assign last_rstn = (PIPE_REGS > 0) ? pipe_rstn : 1'b1;

    always_ff @(posedge mclk) begin
        if (reset || !last_rstn) begin
            acc_reg    <= `FPM_DATA_RST;
            acc_st_reg <= FPM_ST_NORMAL;
        end else if (last_ce) begin
            acc_reg    <= nxt_data;
            acc_st_reg <= nxt_st;
        end
    end

    // Zero stages means a combinational result path
    assign dout   = (PIPE_REGS > 0) ? acc_reg    : nxt_data;
    assign status = (PIPE_REGS > 0) ? acc_st_reg : nxt_st;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_st_zero;
        @(posedge mclk) disable iff (reset)
        (status == FPM_ST_ZERO || status == FPM_ST_UFLOW)
            |-> dout[W-2:0] == '0;
    endproperty
    a_st_zero: assert property (p_st_zero)
        else $error("zero or underflow status with nonzero magnitude");

    property p_st_inf;
        @(posedge mclk) disable iff (reset)
        status == FPM_ST_INF |-> &dout[W-2:W-1-EXP_WIDTH];
    endproperty
    a_st_inf: assert property (p_st_inf)
        else $error("infinity status without all-ones exponent");

    property p_in_take;
        @(posedge mclk) disable iff (reset)
        (IN_REG_EN && ce_a && ce_b && in_rstn)
            |=> a_op == $past(din_a) && b_op == $past(din_b);
    endproperty
    a_in_take: assert property (p_in_take)
        else $error("input registers missed enabled operands");

    property p_in_hold;
        @(posedge mclk) disable iff (reset)
        (IN_REG_EN && !ce_b && in_rstn) |=> $stable(b_op);
    endproperty
    a_in_hold: assert property (p_in_hold)
        else $error("operand B changed with its enable low");

    property p_in_clear;
        @(posedge mclk) disable iff (reset)
        (IN_REG_EN && !in_rstn) |=> a_op == '0 && b_op == '0;
    endproperty
    a_in_clear: assert property (p_in_clear)
        else $error("input reset did not clear operands");

    property p_pipe_clear;
        @(posedge mclk) disable iff (reset)
        (PIPE_REGS > 0 && !pipe_rstn)
            |=> dout == '0 && status == FPM_ST_NORMAL;
    endproperty
    a_pipe_clear: assert property (p_pipe_clear)
        else $error("pipeline reset did not clear the result");

    property p_pipe_hold;
        @(posedge mclk) disable iff (reset)
        (PIPE_REGS > 0 && pipe_rstn && !pipe_ce) |=> $stable(dout);
    endproperty
    a_pipe_hold: assert property (p_pipe_hold)
        else $error("result moved with pipeline enable low");

    property p_load;
        @(posedge mclk) disable iff (reset)
        (ACCUM_EN && PIPE_REGS > 0 && pipe_ce && pipe_rstn && pd_ld)
            |=> dout == $past(pd_data);
    endproperty
    a_load: assert property (p_load)
        else $error("load did not restart the accumulator");

    property p_accum;
        @(posedge mclk) disable iff (reset)
        (ACCUM_EN && PIPE_REGS > 0 && pipe_ce && pipe_rstn && !pd_ld)
            |=> dout == $past(sum_w) && status == $past(sum_st);
    endproperty
    a_accum: assert property (p_accum)
        else $error("accumulator did not keep the sum");

    property p_plain;
        @(posedge mclk) disable iff (reset)
        (!ACCUM_EN && !IN_REG_EN && PIPE_REGS == 1 && pipe_ce && pipe_rstn)
            |=> dout == $past(prod);
    endproperty
    a_plain: assert property (p_plain)
        else $error("product not presented after one stage");

    c_load:  cover property (@(posedge mclk) disable iff (reset)
        pd_ld && ACCUM_EN);
    c_accum: cover property (@(posedge mclk) disable iff (reset)
        !pd_ld && ACCUM_EN ##1 !pd_ld);
    c_inf:   cover property (@(posedge mclk) disable iff (reset)
        status == FPM_ST_INF);
    c_uflow: cover property (@(posedge mclk) disable iff (reset)
        status == FPM_ST_UFLOW);
endmodule : fpm_mac

// ===== verif/fpm_user_model.sv
`timescale 1ns/1ps
module fpm_user_model #(
    parameter int FORMAT_WIDTH = 16
) (
    // Clock
    input  wire logic                    mclk,
    // Global reset
    output logic                         reset,
    // Operands and load
    output logic      [FORMAT_WIDTH-1:0] din_a,
    output logic      [FORMAT_WIDTH-1:0] din_b,
    output logic                         load,
    // Input register control
    output logic                         in_reg_a_ce,
    output logic                         in_reg_b_ce,
    output logic                         in_reg_rst_n,
    // Pipeline control
    output logic                         pipeline_ce,
    output logic                         pipeline_rst_n
);
    // ----------------------------------------------------------------
    // Idle levels at time zero
    // ----------------------------------------------------------------
    initial begin
        reset          = 1'b1;
        din_a          = '0;
        din_b          = '0;
        load           = 1'b1;
        in_reg_a_ce    = 1'b1;
        in_reg_b_ce    = 1'b1;
        in_reg_rst_n   = 1'b1;
        pipeline_ce    = 1'b1;
        pipeline_rst_n = 1'b1;
    end

    // ----------------------------------------------------------------
    // Drivers
    // ----------------------------------------------------------------
    // Falling edge launch keeps every input settled at the rising edge
    task automatic present(input logic [FORMAT_WIDTH-1:0] a,
                           input logic [FORMAT_WIDTH-1:0] b,
                           input logic ld, input logic cea,
                           input logic ceb, input logic rstn);
        @(negedge mclk);
        din_a        <= a;
        din_b        <= b;
        load         <= ld;
        in_reg_a_ce  <= cea;
        in_reg_b_ce  <= ceb;
        in_reg_rst_n <= rstn;
    endtask : present

    // Called at a falling edge already reached, so it does not wait
    task automatic set_pipe(input logic ce, input logic rstn);
        pipeline_ce    <= ce;
        pipeline_rst_n <= rstn;
    endtask : set_pipe

    task automatic do_reset(input int cycles);
        @(negedge mclk);
        reset <= 1'b1;
        repeat (cycles) @(negedge mclk);
        reset <= 1'b0;
    endtask : do_reset
endmodule : fpm_user_model

// ===== verif/fpm_mac_tb_top.sv
`timescale 1ns/1ps
module fpm_mac_tb_top;
    import fpm_pkg::*;
    // ----------------------------------------------------------------
    // Configuration: input registers, two stages, accumulation
    // ----------------------------------------------------------------
    localparam int W   = 16;
    localparam int LAT = 2 + 1;
    typedef struct packed {
        logic [W-1:0] a;
        logic [W-1:0] b;
        logic         ld;
        logic         cea;
        logic         ceb;
        logic         rstn;
        logic [W-1:0] e;
        fpm_status_e  s;
    } fpm_tb_set_s;

    logic          mclk = 1'b0;
    logic          reset;
    logic [W-1:0]  din_a;
    logic [W-1:0]  din_b;
    logic          load;
    logic          in_reg_a_ce;
    logic          in_reg_b_ce;
    logic          in_reg_rst_n;
    logic          pipeline_ce;
    logic          pipeline_rst_n;
    logic [W-1:0]  dout;
    fpm_status_e   status;
    logic [W-1:0]  dout_p;
    fpm_status_e   status_p;
    localparam bit HIDE = 1'b1;
    int            fail_count = 0;
    int            num_checks = 0;
    fpm_tb_set_s   sq[$];

    always #25 mclk = ~mclk;

    fpm_user_model #(.FORMAT_WIDTH(W)) u_fpm_user_model (
        .mclk(mclk), .reset(reset), .din_a(din_a), .din_b(din_b),
        .load(load), .in_reg_a_ce(in_reg_a_ce), .in_reg_b_ce(in_reg_b_ce),
        .in_reg_rst_n(in_reg_rst_n), .pipeline_ce(pipeline_ce),
        .pipeline_rst_n(pipeline_rst_n)
    );

    fpm_mac #(
        .FORMAT_WIDTH(W), .ACCUM_EN(1'b1), .IN_REG_EN(1'b1), .PIPE_REGS(2)
    ) u_fpm_mac (
        .mclk(mclk), .reset(reset), .din_a(din_a), .din_b(din_b),
        .load(load), .in_reg_a_ce(in_reg_a_ce), .in_reg_b_ce(in_reg_b_ce),
        .in_reg_rst_n(in_reg_rst_n), .pipeline_ce(pipeline_ce),
        .pipeline_rst_n(pipeline_rst_n), .dout(dout), .status(status)
    );

    // Second unit: one stage, no accumulation, controls hidden
    fpm_mac #(
        .FORMAT_WIDTH(W), .PIPE_REGS(1), .HIDE_IN_CTRL(HIDE),
        .HIDE_PIPE_CTRL(HIDE)
    ) u_fpm_mac_plain (
        .mclk(mclk), .reset(reset), .din_a(din_a), .din_b(din_b),
        .load(load), .in_reg_a_ce(in_reg_a_ce), .in_reg_b_ce(in_reg_b_ce),
        .in_reg_rst_n(in_reg_rst_n), .pipeline_ce(pipeline_ce),
        .pipeline_rst_n(pipeline_rst_n), .dout(dout_p), .status(status_p)
    );

    // ----------------------------------------------------------------
    // Compare, queue and report helpers
    // ----------------------------------------------------------------
    task automatic chk_data(input string nm, input logic [W-1:0] exp,
                            input logic [W-1:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_data

    task automatic chk_status(input string nm, input fpm_status_e exp,
                              input fpm_status_e got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk_status

    task automatic add(input logic [W-1:0] a, input logic [W-1:0] b,
                       input logic ld, input logic cea, input logic ceb,
                       input logic rstn, input logic [W-1:0] e,
                       input fpm_status_e s);
        sq.push_back({a, b, ld, cea, ceb, rstn, e, s});
    endtask : add

    // One set per cycle back to back; each result is read LAT cycles on
    task automatic run_seq();
        int n;
        n = sq.size();
        for (int i = 0; i < n + LAT; i++) begin
            if (i < n) begin
                u_fpm_user_model.present(sq[i].a, sq[i].b, sq[i].ld,
                                         sq[i].cea, sq[i].ceb, sq[i].rstn);
            end else begin
                u_fpm_user_model.present(16'h0000, 16'h0000, 1'b1,
                                         1'b1, 1'b1, 1'b1);
            end
            if (i >= LAT) begin
                chk_data("dout", sq[i-LAT].e, dout);
                chk_status("status", sq[i-LAT].s, status);
            end
        end
        sq.delete();
    endtask : run_seq

    task automatic wrap_up();
        if (fail_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_accumulate();
        add(16'h4000, 16'h4200, 1'b1, 1, 1, 1, 16'h4600, FPM_ST_NORMAL);
        add(16'h3C00, 16'h3C00, 1'b0, 1, 1, 1, 16'h4700, FPM_ST_NORMAL);
        add(16'h3E00, 16'h4000, 1'b0, 1, 1, 1, 16'h4900, FPM_ST_NORMAL);
        add(16'h4000, 16'h4000, 1'b1, 1, 1, 1, 16'h4400, FPM_ST_NORMAL);
        run_seq();
    endtask : t_accumulate

    // Every status code, each set restarting the sum
    task automatic t_status();
        add(16'h0000, 16'h4000, 1'b1, 1, 1, 1, 16'h0000, FPM_ST_ZERO);
        add(16'h7C00, 16'h4000, 1'b1, 1, 1, 1, 16'h7C00, FPM_ST_INF);
        add(16'h0400, 16'h0400, 1'b1, 1, 1, 1, 16'h0000, FPM_ST_UFLOW);
        add(16'h3C00, 16'h4000, 1'b1, 1, 1, 1, 16'h4000, FPM_ST_NORMAL);
        run_seq();
    endtask : t_status

    // A frozen keeps old A and its load, B frozen keeps old B; clear drops
    task automatic t_in_reg();
        add(16'h4000, 16'h4200, 1'b1, 1, 1, 1, 16'h4600, FPM_ST_NORMAL);
        add(16'h4200, 16'h3E00, 1'b0, 0, 1, 1, 16'h4200, FPM_ST_NORMAL);
        add(16'h3C00, 16'h3C00, 1'b0, 1, 1, 1, 16'h4400, FPM_ST_NORMAL);
        add(16'h4000, 16'h4800, 1'b0, 1, 0, 1, 16'h4600, FPM_ST_NORMAL);
        add(16'h4000, 16'h4200, 1'b0, 1, 1, 0, 16'h4600, FPM_ST_NORMAL);
        run_seq();
    endtask : t_in_reg

    task automatic t_pipe_ctrl();
        add(16'h4000, 16'h4200, 1'b1, 1, 1, 1, 16'h4600, FPM_ST_NORMAL);
        run_seq();
        u_fpm_user_model.set_pipe(1'b0, 1'b1);
        repeat (5) begin
            u_fpm_user_model.present(16'h3C00, 16'h3C00, 1'b0, 1, 1, 1);
            chk_data("frozen dout", 16'h4600, dout);
        end
        u_fpm_user_model.set_pipe(1'b1, 1'b0);
        u_fpm_user_model.present(16'h0000, 16'h0000, 1'b1, 1, 1, 1);
        chk_data("cleared dout", 16'h0000, dout);
        chk_status("cleared status", FPM_ST_NORMAL, status);
        u_fpm_user_model.set_pipe(1'b1, 1'b1);
    endtask : t_pipe_ctrl

    // Hidden controls ignore the pins; load never restarts a sum
    task automatic t_plain();
        u_fpm_user_model.present(16'h4000, 16'h4200, 1'b1, 1, 1, 1);
        u_fpm_user_model.set_pipe(1'b0, 1'b0);
        u_fpm_user_model.present(16'h3E00, 16'h4000, 1'b0, 1, 1, 1);
        chk_data("plain dout", 16'h4600, dout_p);
        chk_status("plain status", FPM_ST_NORMAL, status_p);
        u_fpm_user_model.present(16'h7C00, 16'h4000, 1'b0, 0, 0, 0);
        chk_data("plain dout", 16'h4200, dout_p);
        u_fpm_user_model.present(16'h0000, 16'h0000, 1'b1, 1, 1, 1);
        chk_data("plain dout", 16'h7C00, dout_p);
        chk_status("plain status", FPM_ST_INF, status_p);
        u_fpm_user_model.set_pipe(1'b1, 1'b1);
    endtask : t_plain

    task automatic t_reset(input int cycles);
        u_fpm_user_model.do_reset(cycles);
        chk_data("reset dout", 16'h0000, dout);
        chk_status("reset status", FPM_ST_NORMAL, status);
        chk_data("reset plain dout", 16'h0000, dout_p);
    endtask : t_reset

    initial begin
        t_reset(12);
        t_accumulate();
        t_status();
        t_in_reg();
        t_pipe_ctrl();
        t_plain();
        t_accumulate();
        t_reset(2);
        t_status();
        wrap_up();
    end
endmodule : fpm_mac_tb_top
